/* File: design/lin_slave_header_sync.v */
// lin master/slave header detection, break, auto-sync and fractional divider
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "lin_slave_header_sync_defs.vh"

// Function
// - deferred update in slave mode applies divider at next received character, then self-clears.
// - with no new write, deferred update reloads the previous divider value.
// - software may clear deferred update; divider writes then act directly.
// - enable 0 disables lin; enable 1 picks master or slave by slave bit.
// - master send-break emits thirteen low bit times.
// - slave recognises break after eleven dominant bit times on receive line.
// - send-break has no effect in slave mode.
// - slave mode maps mantissa and fraction over baud and tx prescaler addresses.
// - auto-sync enable turns the sync unit on, only in slave mode.
// - header method: 0 means break alone, 1 means break, synch, identifier.
// - while muted, header method selects leaving mute by break or identifier.
// - header irq enable requests serial interrupt while header flag set, in slave mode only.
// - header flag set by hardware; cleared by status access then lin_control read.
// - synch state set at break, cleared when analysis ends; software clear aborts.
// - auto-sync counts receive-line falling edges to measure the synch field.
// - mantissa zero disables serial clock; 1 to 255 give integer part.
// - fraction in bits 3:0 in sixteenths; upper bits read zero.
// - fraction written first; divider updates only on mantissa write.
// - slave mantissa zero stops transmitter and receiver clocks.
// - header length visible in slave with auto-sync or identifier method; else zero in slave mode, rx prescaler outside slave mode.
// - header length loads ffh at each break, 00h on header timeout.
// - on identifier-method header, load 57 minus header length, quarters in low bits.
// - quarter rounding carry goes into the integer part.
module lin_slave_header_sync (
	// clock and reset
	input wire CORE_CLK,
	input wire RST_N,
	// avalon-mm register slave
	input wire [7:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	output reg [31:0] AVS_READDATA,
	output reg AVS_WAITREQUEST,
	// lin transceiver lines
	input wire LIN_RX,
	output reg LIN_TX,
	// serial interrupt request
	output reg SERIAL_IRQ
);

	localparam ST_IDLE = 4'b0001;
	localparam ST_START = 4'b0010;
	localparam ST_DATA = 4'b0100;
	localparam ST_STOP = 4'b1000;

	function reg_hit;
		input [7:0] addr;
		input [5:0] idx;
		begin
			reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
		end
	endfunction

	// software-visible state
	reg [7:0] baud_rate_reg;
	reg [7:0] extended_tx_prescaler;
	reg [7:0] extended_rx_prescaler;
	reg [7:0] control_one;
	reg [5:0] control_two_hi;
	reg receiver_mute;
	reg send_break;
	reg [7:0] mant_reg;
	reg [3:0] frac_reg;
	reg [7:0] div_mant;
	reg [3:0] div_frac;
	reg [7:0] serial_data;
	reg [7:0] header_length_value;
	reg deferred_divider_update;
	reg lin_enable;
	reg slave_select;
	reg auto_sync_enable;
	reg header_method_select;
	reg header_irq_enable;
	reg header_detected_flag;
	reg synch_field_state;
	reg receive_full_flag;
	reg header_error;
	reg status_seen;

	// header engine
	reg hdr_active;
	reg hdr_ident;
	reg [10:0] hcnt;
	reg [2:0] fall_cnt;
	reg measuring;
	reg [15:0] cyc;

	// baud tick, pin sync, receiver, break tx
	reg [12:0] acc;
	reg s_tick;
	reg rx_m1;
	reg rx_m2;
	reg rx_m3;
	reg receive_line;
	reg rx_prev;
	reg [7:0] low_cnt;
	reg [3:0] rx_state;
	reg [3:0] tcnt;
	reg [2:0] bit_idx;
	reg [7:0] shreg;
	reg char_done;
	reg brk_busy;
	reg [7:0] brk_cnt;
	reg [7:0] rd_mux;

	wire slave_mode = lin_enable & slave_select;
	wire master_mode = lin_enable & ~slave_select;
	wire lhl_visible = slave_mode & (auto_sync_enable | header_method_select);
	wire [11:0] ldiv16 = slave_mode ? {div_mant, div_frac} : {baud_rate_reg, 4'h0};
	wire clk_on = (ldiv16[11:4] != 8'h00);
	wire [12:0] acc_next = acc + `SAMPLE_STEP;
	wire fall = rx_prev & ~receive_line;
	wire break_hit = slave_mode & s_tick & ~receive_line &
		(low_cnt == (`RX_BREAK_TICKS - 8'h01));
	wire auto_run = slave_mode & auto_sync_enable & synch_field_state;
	wire wr = AVS_WRITE & ~AVS_WAITREQUEST;
	wire rd = AVS_READ & ~AVS_WAITREQUEST;
	wire [7:0] wd = AVS_WRITEDATA[7:0];
	wire sw_abort = wr & reg_hit(AVS_ADDRESS, `IDX_LIN_CONTROL) &
		~wd[`LC_SYNCH_FIELD_STATE] & synch_field_state;
	wire rx_kill = break_hit | auto_run | sw_abort;
	wire [10:0] hround = hcnt + 11'h002;
	wire [8:0] hq = hround[10:2];
	wire [8:0] lhl_diff = `HEADER_MAX_QUARTERS - hq;
	wire [7:0] lhl_calc = lhl_diff[7:0];
	wire hdr_timeout = hdr_active & (hcnt > `HEADER_MAX_TICKS);
	wire [11:0] sync_baud_divider = cyc[14:3];
	wire ident_header = hdr_active & hdr_ident & header_method_select;
	wire deliver = char_done & ~synch_field_state &
		(~receiver_mute | ident_header);

	// read multiplexer
	always @* begin
		rd_mux = 8'h00;
		if (reg_hit(AVS_ADDRESS, `IDX_SERIAL_STATUS)) begin
			rd_mux = {1'b1, ~brk_busy, receive_full_flag, 1'b0, header_error, 3'b000};
		end else if (reg_hit(AVS_ADDRESS, `IDX_SERIAL_DATA)) begin
			rd_mux = serial_data;
		end else if (reg_hit(AVS_ADDRESS, `IDX_DIVIDER_MANTISSA)) begin
			rd_mux = slave_mode ? mant_reg : baud_rate_reg;
		end else if (reg_hit(AVS_ADDRESS, `IDX_SERIAL_CONTROL_ONE)) begin
			rd_mux = control_one;
		end else if (reg_hit(AVS_ADDRESS, `IDX_SERIAL_CONTROL_TWO)) begin
			rd_mux = {control_two_hi, receiver_mute, send_break};
		end else if (reg_hit(AVS_ADDRESS, `IDX_LIN_CONTROL)) begin
			rd_mux = {deferred_divider_update, lin_enable, slave_select, auto_sync_enable,
				header_method_select, header_irq_enable, header_detected_flag,
				synch_field_state};
		end else if (reg_hit(AVS_ADDRESS, `IDX_HEADER_LENGTH)) begin
			if (lhl_visible) begin
				rd_mux = header_length_value;
			end else begin
				rd_mux = slave_mode ? 8'h00 : extended_rx_prescaler;
			end
		end else if (reg_hit(AVS_ADDRESS, `IDX_DIVIDER_FRACTION)) begin
			rd_mux = slave_mode ? {4'h0, frac_reg} : extended_tx_prescaler;
		end
	end

	// bus handshake: one wait cycle per access
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h00000000;
		end else begin
			if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST) begin
				AVS_WAITREQUEST <= 1'b0;
			end else begin
				AVS_WAITREQUEST <= 1'b1;
			end
			if (AVS_READ & AVS_WAITREQUEST) begin
				AVS_READDATA <= {24'h000000, rd_mux};
			end
		end
	end

	// sample tick at sixteen per bit from the fractional divider
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			acc <= 13'h0000;
			s_tick <= 1'b0;
		end else if (!clk_on) begin
			acc <= 13'h0000;
			s_tick <= 1'b0;
		end else if (acc_next >= {1'b0, ldiv16}) begin
			acc <= acc_next - {1'b0, ldiv16};
			s_tick <= 1'b1;
		end else begin
			acc <= acc_next;
			s_tick <= 1'b0;
		end
	end

	// receive pin synchroniser, dominant run length
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_m1 <= 1'b1;
			rx_m2 <= 1'b1;
			rx_m3 <= 1'b1;
			receive_line <= 1'b1;
			rx_prev <= 1'b1;
			low_cnt <= 8'h00;
		end else begin
			rx_m1 <= LIN_RX;
			rx_m2 <= rx_m1;
			rx_m3 <= rx_m2;
			if (rx_m2 == rx_m3) begin
				receive_line <= rx_m3;
			end
			rx_prev <= receive_line;
			if (receive_line) begin
				low_cnt <= 8'h00;
			end else if (s_tick && (low_cnt != `RX_BREAK_TICKS)) begin
				low_cnt <= low_cnt + 8'h01;
			end
		end
	end

	// character receiver, mid-bit sampling
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_state <= ST_IDLE;
			tcnt <= 4'h0;
			bit_idx <= 3'h0;
			shreg <= 8'h00;
			char_done <= 1'b0;
		end else begin
			char_done <= 1'b0;
			if (rx_kill || !lin_enable) begin
				rx_state <= ST_IDLE;
			end else begin
				case (rx_state)
				ST_IDLE: begin
					if (fall && clk_on) begin
						rx_state <= ST_START;
						tcnt <= 4'h0;
					end
				end
				ST_START: begin
					if (s_tick) begin
						if (tcnt == `RX_MID_SAMPLE) begin
							rx_state <= receive_line ? ST_IDLE : ST_DATA;
							tcnt <= 4'h0;
							bit_idx <= 3'h0;
						end else begin
							tcnt <= tcnt + 4'h1;
						end
					end
				end
				ST_DATA: begin
					if (s_tick) begin
						tcnt <= tcnt + 4'h1;
						if (tcnt == `RX_LAST_SAMPLE) begin
							shreg <= {receive_line, shreg[7:1]};
							if (bit_idx == 3'h7) begin
								rx_state <= ST_STOP;
							end else begin
								bit_idx <= bit_idx + 3'h1;
							end
						end
					end
				end
				ST_STOP: begin
					if (s_tick) begin
						tcnt <= tcnt + 4'h1;
						if (tcnt == `RX_LAST_SAMPLE) begin
							char_done <= receive_line;
							rx_state <= ST_IDLE;
						end
					end
				end
				default: rx_state <= ST_IDLE;
				endcase
			end
		end
	end

	// master break transmitter
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			brk_busy <= 1'b0;
			brk_cnt <= 8'h00;
			LIN_TX <= 1'b1;
		end else begin
			LIN_TX <= ~brk_busy;
			if (!master_mode) begin
				brk_busy <= 1'b0;
			end else if (!brk_busy) begin
				if (send_break && s_tick) begin
					brk_busy <= 1'b1;
					brk_cnt <= 8'h00;
				end
			end else if (s_tick) begin
				if (brk_cnt == (`TX_BREAK_TICKS - 8'h01)) begin
					brk_busy <= 1'b0;
				end else begin
					brk_cnt <= brk_cnt + 8'h01;
				end
			end
		end
	end

	// interrupt request
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SERIAL_IRQ <= 1'b0;
		end else begin
			SERIAL_IRQ <= slave_mode & header_irq_enable & header_detected_flag;
		end
	end

	// registers and header engine; hardware sets come last so they win
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			baud_rate_reg <= `CONTROL_RESET;
			extended_tx_prescaler <= `CONTROL_RESET;
			extended_rx_prescaler <= `CONTROL_RESET;
			control_one <= `CONTROL_RESET;
			control_two_hi <= 6'h00;
			receiver_mute <= 1'b0;
			send_break <= 1'b0;
			mant_reg <= 8'h00;
			frac_reg <= 4'h0;
			div_mant <= 8'h00;
			div_frac <= 4'h0;
			serial_data <= 8'h00;
			header_length_value <= `HEADER_LENGTH_RESET;
			deferred_divider_update <= 1'b0;
			lin_enable <= 1'b0;
			slave_select <= 1'b0;
			auto_sync_enable <= 1'b0;
			header_method_select <= 1'b0;
			header_irq_enable <= 1'b0;
			header_detected_flag <= 1'b0;
			synch_field_state <= 1'b0;
			receive_full_flag <= 1'b0;
			header_error <= 1'b0;
			status_seen <= 1'b0;
			hdr_active <= 1'b0;
			hdr_ident <= 1'b0;
			hcnt <= 11'h000;
			fall_cnt <= 3'h0;
			measuring <= 1'b0;
			cyc <= 16'h0000;
		end else begin
			// software writes
			if (wr) begin
				if (reg_hit(AVS_ADDRESS, `IDX_DIVIDER_MANTISSA)) begin
					if (slave_mode) begin
						mant_reg <= wd;
						if (!deferred_divider_update) begin
							div_mant <= wd;
							div_frac <= frac_reg;
						end
					end else begin
						baud_rate_reg <= wd;
					end
				end
				if (reg_hit(AVS_ADDRESS, `IDX_SERIAL_CONTROL_ONE)) begin
					control_one <= wd;
				end
				if (reg_hit(AVS_ADDRESS, `IDX_SERIAL_CONTROL_TWO)) begin
					control_two_hi <= wd[7:2];
					send_break <= wd[`SC2_SEND_BREAK];
					if (!(slave_mode && receive_full_flag)) begin
						receiver_mute <= wd[`SC2_RECEIVER_MUTE];
					end
				end
				if (reg_hit(AVS_ADDRESS, `IDX_LIN_CONTROL)) begin
					deferred_divider_update <= wd[`LC_DEFERRED_DIVIDER_UPDATE];
					lin_enable <= wd[`LC_LIN_ENABLE];
					slave_select <= wd[`LC_SLAVE_SELECT];
					auto_sync_enable <= wd[`LC_AUTO_SYNC_ENABLE];
					header_method_select <= wd[`LC_HEADER_METHOD_SELECT];
					header_irq_enable <= wd[`LC_HEADER_IRQ_ENABLE];
					if (sw_abort) begin
						synch_field_state <= 1'b0;
						hdr_active <= 1'b0;
						hdr_ident <= 1'b0;
						measuring <= 1'b0;
					end
				end
				if (reg_hit(AVS_ADDRESS, `IDX_HEADER_LENGTH) && !slave_mode) begin
					extended_rx_prescaler <= wd;
				end
				if (reg_hit(AVS_ADDRESS, `IDX_DIVIDER_FRACTION)) begin
					if (slave_mode) begin
						frac_reg <= wd[3:0];
					end else begin
						extended_tx_prescaler <= wd;
					end
				end
			end
			// clear sequences
			if (rd && reg_hit(AVS_ADDRESS, `IDX_SERIAL_STATUS)) begin
				status_seen <= 1'b1;
			end
			if (rd && status_seen && reg_hit(AVS_ADDRESS, `IDX_SERIAL_DATA)) begin
				receive_full_flag <= 1'b0;
				if (!synch_field_state) begin
					header_error <= 1'b0;
				end
				status_seen <= 1'b0;
			end
			if (rd && status_seen && reg_hit(AVS_ADDRESS, `IDX_LIN_CONTROL)) begin
				header_detected_flag <= 1'b0;
				status_seen <= 1'b0;
			end
			// header engine
			if (measuring && (cyc != 16'hffff)) begin
				cyc <= cyc + 16'h0001;
			end
			if (hdr_active && s_tick) begin
				hcnt <= hcnt + 11'h001;
			end
			if (!slave_mode) begin
				hdr_active <= 1'b0;
				synch_field_state <= 1'b0;
				measuring <= 1'b0;
			end else if (break_hit) begin
				synch_field_state <= 1'b1;
				hdr_active <= 1'b1;
				hdr_ident <= 1'b0;
				hcnt <= {3'h0, `RX_BREAK_TICKS};
				header_length_value <= `HEADER_LENGTH_AFTER_BREAK;
				fall_cnt <= 3'h0;
				measuring <= 1'b0;
				if (!header_method_select) begin
					header_detected_flag <= 1'b1;
					receiver_mute <= 1'b0;
				end
			end else if (hdr_timeout) begin
				header_length_value <= `HEADER_LENGTH_TIMEOUT;
				header_error <= 1'b1;
				hdr_active <= 1'b0;
				synch_field_state <= 1'b0;
				measuring <= 1'b0;
			end else if (auto_run && fall && !sw_abort) begin
				fall_cnt <= fall_cnt + 3'h1;
				if (fall_cnt == 3'h0) begin
					measuring <= 1'b1;
					cyc <= 16'h0001; // this cycle counts, so eight bits give 128 x divider
				end
				if (fall_cnt == `SYNCH_FALLS_LAST) begin
					measuring <= 1'b0;
					synch_field_state <= 1'b0;
					hdr_ident <= 1'b1;
					if (sync_baud_divider[11:4] != 8'h00) begin
						div_mant <= sync_baud_divider[11:4];
						div_frac <= sync_baud_divider[3:0];
						mant_reg <= sync_baud_divider[11:4];
						frac_reg <= sync_baud_divider[3:0];
					end
				end
			end else if (synch_field_state && char_done) begin
				synch_field_state <= 1'b0;
				hdr_ident <= 1'b1;
			end else if (char_done && hdr_active && hdr_ident) begin
				hdr_active <= 1'b0;
				hdr_ident <= 1'b0;
				if (header_method_select) begin
					header_detected_flag <= 1'b1;
					header_length_value <= lhl_calc;
					receiver_mute <= 1'b0;
				end
			end
			// character delivery and deferred divider load
			if (deliver) begin
				receive_full_flag <= 1'b1;
				serial_data <= shreg;
				if (slave_mode && deferred_divider_update) begin
					div_mant <= mant_reg;
					div_frac <= frac_reg;
					deferred_divider_update <= 1'b0;
				end
			end
		end
	end

endmodule // lin_slave_header_sync

/* File: design/lin_slave_header_sync_defs.vh */
// register map, field positions, reset values and bit-time counts of the lin header block
`ifndef LIN_SLAVE_HEADER_SYNC_DEFS_VH
`define LIN_SLAVE_HEADER_SYNC_DEFS_VH

// register indices; byte address is four times the index
`define IDX_SERIAL_STATUS 6'h18
`define IDX_SERIAL_DATA 6'h19
`define IDX_DIVIDER_MANTISSA 6'h1a
`define IDX_SERIAL_CONTROL_ONE 6'h1b
`define IDX_SERIAL_CONTROL_TWO 6'h1c
`define IDX_LIN_CONTROL 6'h1d
`define IDX_HEADER_LENGTH 6'h1e
`define IDX_DIVIDER_FRACTION 6'h1f

// lin_control fields
`define LC_DEFERRED_DIVIDER_UPDATE 7
`define LC_LIN_ENABLE 6
`define LC_SLAVE_SELECT 5
`define LC_AUTO_SYNC_ENABLE 4
`define LC_HEADER_METHOD_SELECT 3
`define LC_HEADER_IRQ_ENABLE 2
`define LC_HEADER_DETECTED_FLAG 1
`define LC_SYNCH_FIELD_STATE 0

// serial_control_two fields
`define SC2_RECEIVER_MUTE 1
`define SC2_SEND_BREAK 0

// reset values
`define SERIAL_STATUS_RESET 8'hc0
`define CONTROL_RESET 8'h00
`define HEADER_LENGTH_RESET 8'h00

// header length loads
`define HEADER_LENGTH_AFTER_BREAK 8'hff
`define HEADER_LENGTH_TIMEOUT 8'h00

// bit-time figures
`define SAMPLES_PER_BIT 16
`define SAMPLE_STEP 13'h010
`define TX_BREAK_BITS 13
`define RX_BREAK_BITS 11
`define HEADER_MAX_BITS 57
`define TX_BREAK_TICKS 8'hd0
`define RX_BREAK_TICKS 8'hb0
`define HEADER_MAX_TICKS 11'h390
`define HEADER_MAX_QUARTERS 9'he4
`define SYNCH_FALLS_LAST 3'h4
`define RX_MID_SAMPLE 4'h7
`define RX_LAST_SAMPLE 4'hf

`endif

/* File: sim/lin_header_monitor.sv */
// assertion checker for the lin header block ports
`timescale 1ns/1ps
module lin_header_monitor (
	// clock and reset
	input wire CORE_CLK,
	input wire RST_N,
	// register bus
	input wire [7:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [31:0] AVS_READDATA,
	input wire AVS_WAITREQUEST,
	// lin lines and interrupt
	input wire LIN_RX,
	input wire LIN_TX,
	input wire SERIAL_IRQ
);
	localparam int BREAK_MIN = 208;
	reg [15:0] low_run;
	wire lin_ctl_hit;
	assign lin_ctl_hit = !AVS_WAITREQUEST && (AVS_ADDRESS == 8'h74);
	// length of the current low run on the transmit line
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			low_run <= 16'h0000;
		end else if (!LIN_TX) begin
			low_run <= low_run + 16'h0001;
		end else begin
			low_run <= 16'h0000;
		end
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	sequence s_req_seen;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
	endsequence
	sequence s_done;
		!AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endsequence
	a_req_answer: assert property (s_req_seen |=> s_done)
		else $error("request not completed in one cycle");
	a_no_spurious: assert property (!AVS_WAITREQUEST |-> $past(AVS_READ || AVS_WRITE))
		else $error("completion without request");
	a_upper_zero: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_unmapped_zero: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS < 8'h60
		|-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	a_status_fixed: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 8'h60
		|-> (AVS_READDATA[7:0] & 8'h97) == 8'h80)
		else $error("status fixed bits wrong");
	a_break_length: assert property ($rose(LIN_TX) |-> low_run >= BREAK_MIN)
		else $error("transmit low run shorter than a break");
	a_reset_idle: assert property ($rose(RST_N) |-> !SERIAL_IRQ && LIN_TX && AVS_WAITREQUEST)
		else $error("outputs not idle after reset");
	a_irq_cause: assert property ($fell(SERIAL_IRQ) |-> $past(lin_ctl_hit, 1)
		|| $past(lin_ctl_hit, 2) || $past(lin_ctl_hit, 3))
		else $error("interrupt dropped without control access");
endmodule // lin_header_monitor

bind lin_slave_header_sync lin_header_monitor mon (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
	.AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .LIN_RX(LIN_RX), .LIN_TX(LIN_TX),
	.SERIAL_IRQ(SERIAL_IRQ));

/* File: sim/lin_node_model.sv */
// lin bus master node driving the receive line
`timescale 1ns/1ps
module lin_node_model #(
	parameter BIT_CYCLES = 16
) (
	// clock
	input wire clk,
	// bus line, pulled up when idle
	output reg rx_line
);
	initial rx_line = 1'b1;
	// dominant break, then a recessive delimiter bit
	task send_break(input integer bits);
		begin
			@(posedge clk);
			rx_line <= 1'b0;
			repeat (bits * BIT_CYCLES) @(posedge clk);
			rx_line <= 1'b1;
			repeat (BIT_CYCLES) @(posedge clk);
		end
	endtask
	// start bit, eight data bits lsb first, stop bit
	task send_byte(input [7:0] b);
		integer i;
		begin
			rx_line <= 1'b0;
			repeat (BIT_CYCLES) @(posedge clk);
			for (i = 0; i < 8; i = i + 1) begin
				rx_line <= b[i];
				repeat (BIT_CYCLES) @(posedge clk);
			end
			rx_line <= 1'b1;
			repeat (BIT_CYCLES) @(posedge clk);
		end
	endtask
endmodule // lin_node_model

/* File: sim/testbench.sv */
// self-checking testbench for the lin header block
`timescale 1ns/1ps
`include "lin_slave_header_sync_defs.vh"
module testbench;
	reg core_clk = 1'b0;
	reg rst_n = 1'b0;
	reg [7:0] address = 8'h00;
	reg rd = 1'b0;
	reg wr = 1'b0;
	reg [31:0] wdata = 32'h0;
	wire [31:0] rdata;
	wire waitreq;
	wire rx_line;
	wire tx_line;
	wire irq;
	integer miscompares = 0;
	integer checked = 0;
	integer tx_lows = 0;
	integer n;
	reg [7:0] got;
	localparam [7:0] A_STATUS = {`IDX_SERIAL_STATUS, 2'b00};
	localparam [7:0] A_DATA = {`IDX_SERIAL_DATA, 2'b00};
	localparam [7:0] A_MANT = {`IDX_DIVIDER_MANTISSA, 2'b00};
	localparam [7:0] A_CTL2 = {`IDX_SERIAL_CONTROL_TWO, 2'b00};
	localparam [7:0] A_LINCTL = {`IDX_LIN_CONTROL, 2'b00};
	localparam [7:0] A_HLEN = {`IDX_HEADER_LENGTH, 2'b00};
	localparam [7:0] A_FRAC = {`IDX_DIVIDER_FRACTION, 2'b00};
	lin_slave_header_sync DUT (.CORE_CLK(core_clk), .RST_N(rst_n), .AVS_ADDRESS(address),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .LIN_RX(rx_line), .LIN_TX(tx_line), .SERIAL_IRQ(irq));
	lin_node_model #(.BIT_CYCLES(32)) node (.clk(core_clk), .rx_line(rx_line));
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (tx_line === 1'b0) tx_lows = tx_lows + 1;
	end
	task check(input [31:0] seen, input [31:0] exp, input string what);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
			end
		end
	endtask
	// one avalon transfer, held until waitrequest is sampled low
	task bus_access(input [7:0] a, input w, input [7:0] d);
		begin
			@(posedge core_clk);
			address <= a;
			rd <= !w;
			wr <= w;
			wdata <= {24'h0, d};
			n = 0;
			@(posedge core_clk);
			while (waitreq !== 1'b0 && n < 50) begin
				@(posedge core_clk);
				n = n + 1;
			end
			if (n >= 50) check(1'b0, 1'b1, "bus timeout");
			got = rdata[7:0];
			rd <= 1'b0;
			wr <= 1'b0;
		end
	endtask
	task wr8(input [7:0] a, input [7:0] d);
		bus_access(a, 1'b1, d);
	endtask
	task expect_reg(input [7:0] a, input [7:0] exp, input string what);
		begin
			bus_access(a, 1'b0, 8'h00);
			check(got, exp, what);
		end
	endtask
	task t_reset_values;
		begin
			expect_reg(A_STATUS, `SERIAL_STATUS_RESET, "status reset");
			expect_reg(A_LINCTL, `CONTROL_RESET, "lin control reset");
			expect_reg(A_MANT, 8'h00, "divider reset");
			expect_reg(A_HLEN, `HEADER_LENGTH_RESET, "length reset");
			expect_reg(A_FRAC, 8'h00, "fraction reset");
			expect_reg(A_CTL2, 8'h00, "control two reset");
			expect_reg(8'h00, 8'h00, "unmapped read");
			$display("test reset_values done");
		end
	endtask
	task t_slave_divider;
		begin
			wr8(A_LINCTL, 8'h60);
			wr8(A_FRAC, 8'hf3);
			wr8(A_MANT, 8'h01);
			expect_reg(A_FRAC, 8'h03, "fraction field");
			expect_reg(A_MANT, 8'h01, "mantissa at shared address");
			expect_reg(A_HLEN, 8'h00, "length hidden");
			$display("test slave_divider done");
		end
	endtask
	// slave sees a break while its own send-break is requested
	task t_slave_break(input [7:0] mant, input [7:0] ctl, input [7:0] exp_ctl,
		input exp_irq, input [7:0] exp_len);
		begin
			wr8(A_LINCTL, ctl);
			wr8(A_FRAC, 8'h00);
			wr8(A_MANT, mant);
			wr8(A_CTL2, 8'h01);
			tx_lows = 0;
			node.send_break(13);
			expect_reg(A_LINCTL, exp_ctl, "flags after break");
			check(irq, exp_irq, "irq after break");
			check(tx_lows, 0, "slave sent break");
			expect_reg(A_HLEN, exp_len, "length after break");
			bus_access(A_STATUS, 1'b0, 8'h00);
			bus_access(A_LINCTL, 1'b0, 8'h00);
			expect_reg(A_LINCTL, exp_ctl & 8'hfd, "flag cleared");
			repeat (2) @(posedge core_clk);
			check(irq, 1'b0, "irq after clear");
			wr8(A_LINCTL, ctl);
			expect_reg(A_LINCTL, ctl, "synch state cleared");
			wr8(A_CTL2, 8'h00);
			$display("test slave_break %h done", ctl);
		end
	endtask
	// auto-sync header, mistuned divider, deferred update pending
	task t_auto_header;
		begin
			wr8(A_LINCTL, 8'h7c);
			wr8(A_FRAC, 8'h01);
			wr8(A_MANT, 8'h02);
			wr8(A_LINCTL, 8'hfc);
			node.send_break(13);
			node.send_byte(8'h55);
			node.send_byte(8'h3c);
			expect_reg(A_LINCTL, 8'h7e, "header by identifier");
			check(irq, 1'b1, "irq after header");
			expect_reg(A_MANT, 8'h02, "synced mantissa");
			expect_reg(A_FRAC, 8'h00, "synced fraction");
			expect_reg(A_STATUS, 8'he0, "status after identifier");
			expect_reg(A_DATA, 8'h3c, "identifier data");
			bus_access(A_HLEN, 1'b0, 8'h00);
			check(got >= 8'h5c && got <= 8'h62, 1, "header length");
			$display("test auto_header done");
		end
	endtask
	task t_master_break;
		begin
			wr8(A_LINCTL, 8'h00);
			wr8(A_MANT, 8'h01);
			tx_lows = 0;
			wr8(A_CTL2, 8'h01);
			repeat (300) @(posedge core_clk);
			check(tx_lows, 0, "disabled sent break");
			wr8(A_CTL2, 8'h00);
			wr8(A_LINCTL, 8'h40);
			tx_lows = 0;
			wr8(A_CTL2, 8'h01);
			n = 0;
			while (tx_line !== 1'b0 && n < 100) begin
				@(posedge core_clk);
				n = n + 1;
			end
			wr8(A_CTL2, 8'h00);
			n = 0;
			while (tx_line !== 1'b1 && n < 1000) begin
				@(posedge core_clk);
				n = n + 1;
			end
			check(tx_lows >= 13 * 16 && tx_lows <= 13 * 16 + 2, 1, "break length");
			$display("test master_break done");
		end
	endtask
	task wrap_up;
		begin
			$display("checked %0d miscompares %0d", checked, miscompares);
			if (miscompares == 0 && checked > 0) begin
				$display("Regression OK");
			end else begin
				$display("Regression broken");
			end
			$finish;
		end
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset_values;
		t_slave_divider;
		t_slave_break(8'h00, 8'h64, 8'h64, 1'b0, 8'h00);
		t_slave_break(8'h01, 8'h64, 8'h67, 1'b1, 8'h00);
		t_slave_break(8'h01, 8'h6c, 8'h6d, 1'b0, `HEADER_LENGTH_AFTER_BREAK);
		t_auto_header;
		t_master_break;
		wrap_up;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		miscompares = miscompares + 1;
		wrap_up;
	end
endmodule // testbench
